//--- core/oscsp_edge_watch.sv
// Edge watcher: counts loop clock edges between oscillator edges
`timescale 1ns/1ps
`default_nettype none
module oscsp_edge_watch
   import oscsp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic osc_clk_lvl,
   input wire logic pll_clk_lvl,
   input wire logic watch_en,
   output wire logic osc_rise,
   output wire logic pll_rise,
   output wire logic clk_missing
);
   oscsp_sup_s s_ff;
   oscsp_sup_s nxt_s;

   always_comb begin
      nxt_s = s_ff;
      nxt_s.osc_prev = osc_clk_lvl;
      nxt_s.pll_prev = pll_clk_lvl;
      nxt_s.osc_rise = osc_clk_lvl & ~s_ff.osc_prev;
      nxt_s.pll_rise = pll_clk_lvl & ~s_ff.pll_prev;
      nxt_s.missing = 1'b0;
      // Any oscillator transition proves it alive
      if (!watch_en || (osc_clk_lvl != s_ff.osc_prev)) begin
         nxt_s.miss_cnt = 5'h00;
      end else if (nxt_s.pll_rise && (s_ff.miss_cnt != MISS_LIMIT)) begin
         nxt_s.miss_cnt = s_ff.miss_cnt + 5'h01;
         // Single pulse: counter parks at the limit
         nxt_s.missing = (s_ff.miss_cnt + 5'h01) == MISS_LIMIT;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign osc_rise = s_ff.osc_rise;
   assign pll_rise = s_ff.pll_rise;
   assign clk_missing = s_ff.missing;
endmodule
`default_nettype wire

//--- core/oscsp_pkg.sv
// Constants, modes and carriers for the oscillator supervisor and power control block
package oscsp_pkg;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFS_SYSCFG = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_CLKMGMT = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_PGATE = 12'h008;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h00c;
   localparam logic [ADDR_W-1:0] OFS_IRQCLR = 12'h010;
   localparam logic [ADDR_W-1:0] OFS_IRQEN = 12'h014;
   localparam int SYS_DIS_BIT = 0;
   localparam int SYS_PRESC_BIT = 1;
   localparam int SYS_PM_LSB = 2;
   localparam int CLK_SLOW_BIT = 0;
   localparam int CLK_DIV_LSB = 1;
   localparam int CLK_PLLOFF_BIT = 6;
   localparam int CLK_RTC_BIT = 7;
   localparam int PG_GROUP_BIT = 16;
   localparam int ST_FAIL_BIT = 0;
   localparam int ST_FB_BIT = 8;
   localparam int ST_PM_LSB = 9;
   localparam int ST_PLL_BIT = 11;
   localparam int NPERIPH = 16;
   localparam logic [NPERIPH-1:0] GROUP_MASK = 16'hfff0;
   localparam logic [4:0] MISS_LIMIT = 5'h10;
   localparam logic [31:0] RST_DATA = 32'h0000_0000;
   localparam logic [NPERIPH-1:0] RST_GATE = 16'h0000;
   typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_SLEEP, PM_PWRDN} oscsp_pmode_e;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } oscsp_apb_req_s;
   typedef struct packed {
      logic osc_prev;
      logic pll_prev;
      logic [4:0] miss_cnt;
      logic missing;
      logic osc_rise;
      logic pll_rise;
   } oscsp_sup_s;
endpackage

//--- core/oscsp_top.sv
// Oscillator supervisor, clock fallback, power modes and peripheral gating
`timescale 1ns/1ps
`default_nettype none
module oscsp_top
   import oscsp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output wire logic [31:0] prdata,
   output wire logic pready,
   output wire logic pslverr,
   input wire logic osc_clk_lvl,
   input wire logic pll_clk_lvl,
   input wire logic rd_strobe_n,
   input wire logic ext_irq,
   output wire logic cpu_clk_tick,
   output wire logic periph_clk_tick,
   output wire logic [NPERIPH-1:0] periph_clk_en,
   output wire logic pll_run,
   output wire logic rtc_run,
   output wire logic on_fallback,
   output wire logic irq
);
   typedef struct packed {
      logic strap_done;
      logic sup_disable;
      logic presc;
      oscsp_pmode_e pmode;
      logic slow_en;
      logic [4:0] slow_div;
      logic pll_off;
      logic rtc_keep;
      logic [NPERIPH-1:0] gate;
      logic group;
      logic fail_sticky;
      logic irq_en;
      logic fallback;
      logic [6:0] divcnt;
      logic cpu_tick;
      logic per_tick;
      logic pll_run;
      logic rtc_run;
      logic irq;
      logic [NPERIPH-1:0] per_en;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } oscsp_top_s;

   oscsp_top_s s_ff;
   oscsp_top_s nxt_s;
   oscsp_apb_req_s req;
   logic osc_rise;
   logic pll_rise;
   logic clk_missing;
   logic watch_en;

   // Source ticks per CPU tick
   function automatic logic [6:0] div_total(input logic fb, input logic presc,
                                            input logic slow, input logic [4:0] f);
      logic [6:0] base;
      base = (slow && !fb) ? ({2'b00, f} + 7'h01) : 7'h01;
      return presc ? {base[5:0], 1'b0} : base;
   endfunction

   assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};

   // Loop must run to supervise; a switched-off loop suspends watching
   assign watch_en = s_ff.strap_done && !s_ff.sup_disable && !s_ff.fallback && s_ff.pll_run;

   oscsp_edge_watch u_watch (
      .pclk(pclk),
      .presetn(presetn),
      .osc_clk_lvl(osc_clk_lvl),
      .pll_clk_lvl(pll_clk_lvl),
      .watch_en(watch_en),
      .osc_rise(osc_rise),
      .pll_rise(pll_rise),
      .clk_missing(clk_missing)
   );

   always_comb begin
      logic acc;
      logic wr;
      logic src_tick;
      logic tick;
      logic [6:0] total;
      logic [31:0] rd;
      logic mapped;
      acc = 1'b0;
      wr = 1'b0;
      src_tick = 1'b0;
      tick = 1'b0;
      total = 7'h01;
      rd = RST_DATA;
      mapped = 1'b1;
      nxt_s = s_ff;
      nxt_s.cpu_tick = 1'b0;
      nxt_s.per_tick = 1'b0;
      nxt_s.pready = 1'b0;
      nxt_s.pslverr = 1'b0;

      // Strap caught on the first edge after release, never under reset
      if (!s_ff.strap_done) begin
         nxt_s.strap_done = 1'b1;
         nxt_s.sup_disable = ~rd_strobe_n;
      end

      acc = req.psel && req.penable;
      wr = acc && s_ff.pready && req.pwrite;
      case (req.paddr)
         OFS_SYSCFG: begin
            rd[SYS_DIS_BIT] = s_ff.sup_disable;
            rd[SYS_PRESC_BIT] = s_ff.presc;
            rd[SYS_PM_LSB +: 2] = s_ff.pmode;
         end
         OFS_CLKMGMT: begin
            rd[CLK_SLOW_BIT] = s_ff.slow_en;
            rd[CLK_DIV_LSB +: 5] = s_ff.slow_div;
            rd[CLK_PLLOFF_BIT] = s_ff.pll_off;
            rd[CLK_RTC_BIT] = s_ff.rtc_keep;
         end
         OFS_PGATE: begin
            rd[NPERIPH-1:0] = s_ff.gate;
            rd[PG_GROUP_BIT] = s_ff.group;
         end
         OFS_STATUS: begin
            rd[ST_FAIL_BIT] = s_ff.fail_sticky;
            rd[ST_FB_BIT] = s_ff.fallback;
            rd[ST_PM_LSB +: 2] = s_ff.pmode;
            rd[ST_PLL_BIT] = s_ff.pll_run;
         end
         OFS_IRQCLR: rd = RST_DATA;
         OFS_IRQEN: rd[ST_FAIL_BIT] = s_ff.irq_en;
         default: mapped = 1'b0;
      endcase
      // One wait state: answer in the second access cycle
      if (acc && !s_ff.pready) begin
         nxt_s.pready = 1'b1;
         nxt_s.prdata = req.pwrite ? RST_DATA : rd;
         nxt_s.pslverr = !mapped;
      end

      if (wr) begin
         case (req.paddr)
            OFS_SYSCFG: begin
               nxt_s.sup_disable = req.pwdata[SYS_DIS_BIT];
               nxt_s.presc = req.pwdata[SYS_PRESC_BIT];
               if (req.pwdata[SYS_PM_LSB +: 2] != 2'b00) begin
                  nxt_s.pmode = oscsp_pmode_e'(req.pwdata[SYS_PM_LSB +: 2]);
               end
            end
            OFS_CLKMGMT: begin
               nxt_s.slow_en = req.pwdata[CLK_SLOW_BIT];
               nxt_s.slow_div = req.pwdata[CLK_DIV_LSB +: 5];
               nxt_s.pll_off = req.pwdata[CLK_PLLOFF_BIT];
               nxt_s.rtc_keep = req.pwdata[CLK_RTC_BIT];
            end
            OFS_PGATE: begin
               nxt_s.gate = req.pwdata[NPERIPH-1:0];
               nxt_s.group = req.pwdata[PG_GROUP_BIT];
            end
            OFS_IRQCLR: nxt_s.fail_sticky = s_ff.fail_sticky & ~req.pwdata[ST_FAIL_BIT];
            OFS_IRQEN: nxt_s.irq_en = req.pwdata[ST_FAIL_BIT];
            default: nxt_s.irq_en = s_ff.irq_en;
         endcase
      end

      // Detection is gated by watch_en, so a disabled watch sets nothing
      // A pulse that lands just as supervision is switched off is dropped
      if (clk_missing && watch_en) begin
         nxt_s.fallback = 1'b1;
         nxt_s.fail_sticky = 1'b1;
      end
      nxt_s.irq = nxt_s.fail_sticky & nxt_s.irq_en;

      // Loop idles when disabled, or when switched off in slow-down, but always runs while on fallback
      // Held off until the strap is in, so a strapped-off loop never runs for a cycle
      nxt_s.pll_run = s_ff.strap_done && (s_ff.fallback || !(s_ff.sup_disable ||
                      (s_ff.slow_en && s_ff.pll_off)));

      src_tick = s_ff.fallback ? pll_rise : osc_rise;
      total = div_total(s_ff.fallback, s_ff.presc, s_ff.slow_en, s_ff.slow_div);
      if (src_tick) begin
         if (s_ff.divcnt >= total - 7'h01) begin
            nxt_s.divcnt = 7'h00;
            tick = 1'b1;
         end else begin
            nxt_s.divcnt = s_ff.divcnt + 7'h01;
         end
      end
      nxt_s.cpu_tick = tick && (s_ff.pmode == PM_RUN);
      nxt_s.per_tick = tick && (s_ff.pmode == PM_RUN || s_ff.pmode == PM_IDLE);

      if (s_ff.pmode == PM_SLEEP || s_ff.pmode == PM_PWRDN) begin
         nxt_s.per_en = '0;
         nxt_s.rtc_run = s_ff.rtc_keep;
      end else begin
         nxt_s.per_en = ~(s_ff.gate | (s_ff.group ? GROUP_MASK : RST_GATE));
         nxt_s.rtc_run = 1'b1;
      end

      // Power down ignores wake events; only reset or a non-zero mode write to SYSCFG leaves it
      case (s_ff.pmode)
         PM_IDLE: if (ext_irq || s_ff.irq) nxt_s.pmode = PM_RUN;
         PM_SLEEP: if (ext_irq) nxt_s.pmode = PM_RUN;
         default: nxt_s.pmode = nxt_s.pmode;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign prdata = s_ff.prdata;
   assign pready = s_ff.pready;
   assign pslverr = s_ff.pslverr;
   assign cpu_clk_tick = s_ff.cpu_tick;
   assign periph_clk_tick = s_ff.per_tick;
   assign periph_clk_en = s_ff.per_en;
   assign pll_run = s_ff.pll_run;
   assign rtc_run = s_ff.rtc_run;
   assign on_fallback = s_ff.fallback;
   assign irq = s_ff.irq;

   fallback_stays_a: assert property (@(posedge pclk) disable iff (!presetn)
      s_ff.fallback |=> s_ff.fallback)
      else $error("fallback left without reset");
   fail_flagged_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s_ff.fallback) |-> s_ff.fail_sticky)
      else $error("fallback without fail flag");
   no_fail_dis_a: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.strap_done && s_ff.sup_disable && !s_ff.fallback) |=> !s_ff.fallback)
      else $error("fallback while supervision disabled");
   pll_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.sup_disable && !s_ff.fallback) |=> !s_ff.pll_run)
      else $error("loop running while disabled");
   pll_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.slow_en && s_ff.pll_off && !s_ff.fallback) |=> !s_ff.pll_run)
      else $error("loop running while switched off");
   idle_cpu_a: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.pmode != PM_RUN) |=> !s_ff.cpu_tick)
      else $error("cpu tick outside run mode");
   sleep_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.pmode == PM_SLEEP || s_ff.pmode == PM_PWRDN) |=> (!s_ff.per_tick && s_ff.per_en == '0))
      else $error("clocks running in sleep");
   strap_load_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s_ff.strap_done) |-> (s_ff.sup_disable == !$past(rd_strobe_n)))
      else $error("disable bit not loaded from strobe");
   group_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.group && s_ff.pmode == PM_RUN) |=> ((s_ff.per_en & GROUP_MASK) == '0))
      else $error("group gate not applied");
   div_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
      (s_ff.fallback ? pll_rise : osc_rise) |=>
      ($changed({s_ff.fallback, s_ff.presc, s_ff.slow_en, s_ff.slow_div}) ||
      (s_ff.divcnt < div_total(s_ff.fallback, s_ff.presc, s_ff.slow_en, s_ff.slow_div))))
      else $error("divider count out of range");
endmodule
`default_nettype wire

//--- tb/oscsp_clk_src.sv
// Behavioural oscillator and loop clock sources feeding the supervisor
`timescale 1ns/1ps
`default_nettype none
module oscsp_clk_src #(
   parameter real OSC_HALF = 17.0,
   parameter real PLL_HALF = 12.0
) (
   input wire logic osc_stop,
   input wire logic pll_en,
   output var logic osc_clk_lvl,
   output var logic pll_clk_lvl
);
   // A dead crystal freezes at its last level, so no edges reach the watcher
   initial osc_clk_lvl = 1'b0;
   always #(OSC_HALF) if (!osc_stop) osc_clk_lvl = ~osc_clk_lvl;
   // Own timebase, unrelated in phase and rate to the oscillator
   // Idle loop gives no clock at all, held low
   initial pll_clk_lvl = 1'b0;
   always #(PLL_HALF) pll_clk_lvl = pll_en ? ~pll_clk_lvl : 1'b0;
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the oscillator supervisor and power control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import oscsp_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic rd_strobe_n = 1'b1, ext_irq = 1'b0, osc_stop = 1'b0, osc_q = 1'b0, pll_q = 1'b0;
   wire [31:0] prdata;
   wire pready, pslverr, osc_clk_lvl, pll_clk_lvl, cpu_clk_tick, periph_clk_tick;
   wire pll_run, rtc_run, on_fallback, irq;
   wire [NPERIPH-1:0] periph_clk_en;
   int n_errors = 0, checks = 0, n_osc = 0, n_pll = 0, n_cpu = 0, n_per = 0;
   logic [31:0] lfsr = 32'h0001_61ff;

   always #2.5 pclk = ~pclk;

   oscsp_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .osc_clk_lvl(osc_clk_lvl), .pll_clk_lvl(pll_clk_lvl),
      .rd_strobe_n(rd_strobe_n), .ext_irq(ext_irq), .cpu_clk_tick(cpu_clk_tick),
      .periph_clk_tick(periph_clk_tick), .periph_clk_en(periph_clk_en), .pll_run(pll_run),
      .rtc_run(rtc_run), .on_fallback(on_fallback), .irq(irq));
   oscsp_clk_src u_src (.osc_stop(osc_stop), .pll_en(pll_run), .osc_clk_lvl(osc_clk_lvl),
      .pll_clk_lvl(pll_clk_lvl));

   // Edge counts seen at pclk, the same sampling the design uses
   always @(posedge pclk) begin
      osc_q <= osc_clk_lvl;
      pll_q <= pll_clk_lvl;
      n_osc <= n_osc + int'(osc_clk_lvl & ~osc_q);
      n_pll <= n_pll + int'(pll_clk_lvl & ~pll_q);
      n_cpu <= n_cpu + int'(cpu_clk_tick);
      n_per <= n_per + int'(periph_clk_tick);
   end

   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [NPERIPH-1:0] exp_en(input logic [31:0] g);
      return ~g[NPERIPH-1:0] & (g[PG_GROUP_BIT] ? ~GROUP_MASK : '1);
   endfunction

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Tick counts are judged within one, since a window cuts a divider period
   task automatic chk_near(input string name, input int exp, input int got);
      checks++;
      if (got < exp - 1 || got > exp + 1) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (i == 50) begin
         n_errors++;
         conclude();
      end
   endtask

   // First n source rises settle the divider, the next 4n are counted
   task automatic measure(input logic use_pll, input int n, input string name);
      int s0, c0, i;
      c0 = 0;
      for (int j = 0; j < 2; j++) begin
         s0 = use_pll ? n_pll : n_osc;
         c0 = n_cpu;
         i = 0;
         while (((use_pll ? n_pll : n_osc) - s0) < ((j == 0) ? n : 4 * n) && i < 20000) begin
            @(posedge pclk);
            i++;
         end
         if (i == 20000) begin
            n_errors++;
            conclude();
         end
      end
      chk_near(name, 4, n_cpu - c0);
   endtask

   task automatic wake();
      @(posedge pclk);
      ext_irq <= 1'b1;
      repeat (3) @(posedge pclk);
      ext_irq <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask

   initial begin
      repeat (100000) @(posedge pclk);
      n_errors++;
      conclude();
   end

   initial begin
      logic [31:0] rd, g;
      logic err, p;
      int f, c0, q0, i;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      apb(1'b0, 12'h020, 32'h0, rd, err);
      chk("unmapped error", 32'h1, err);
      chk("unmapped data", 32'h0, rd);
      apb(1'b0, OFS_SYSCFG, 32'h0, rd, err);
      chk("strap high", 32'h0, rd[SYS_DIS_BIT]);
      chk("loop running", 32'h1, pll_run);
      for (int k = 0; k < 3; k++) begin
         lfsr = next_rand(lfsr);
         g = (k == 0) ? 32'h0001_0000 : lfsr & 32'h0001_ffff;
         apb(1'b1, OFS_PGATE, g, rd, err);
         repeat (3) @(posedge pclk);
         chk("periph enables", exp_en(g), periph_clk_en);
      end
      apb(1'b1, OFS_PGATE, 32'h0, rd, err);
      for (int k = 0; k < 4; k++) begin
         lfsr = next_rand(lfsr);
         f = (k == 0) ? 32 : (k == 1) ? 1 : int'(lfsr[4:0]) + 1;
         p = lfsr[8];
         apb(1'b1, OFS_SYSCFG, {30'h0, p, 1'b0}, rd, err);
         apb(1'b1, OFS_CLKMGMT, {26'h0, 5'(f - 1), 1'b1}, rd, err);
         measure(1'b0, f * (p ? 2 : 1), "slow ticks");
      end
      apb(1'b1, OFS_CLKMGMT, 32'h0000_0041, rd, err);
      repeat (3) @(posedge pclk);
      chk("loop off", 32'h0, pll_run);
      apb(1'b1, OFS_CLKMGMT, 32'h0, rd, err);
      apb(1'b1, OFS_SYSCFG, 32'h4, rd, err);
      repeat (3) @(posedge pclk);
      c0 = n_cpu;
      q0 = n_per;
      repeat (200) @(posedge pclk);
      chk("idle cpu", 32'h0, n_cpu - c0);
      chk("idle periph", 32'h1, n_per > q0);
      wake();
      apb(1'b0, OFS_SYSCFG, 32'h0, rd, err);
      chk("idle wake", 32'h0, rd[3:2]);
      apb(1'b1, OFS_CLKMGMT, 32'h0000_0080, rd, err);
      apb(1'b1, OFS_SYSCFG, 32'h8, rd, err);
      repeat (3) @(posedge pclk);
      c0 = n_cpu;
      q0 = n_per;
      repeat (200) @(posedge pclk);
      chk("sleep ticks", 32'h0, (n_cpu - c0) + (n_per - q0));
      chk("sleep gates", 32'h0, periph_clk_en);
      chk("sleep rtc", 32'h1, rtc_run);
      wake();
      apb(1'b0, OFS_SYSCFG, 32'h0, rd, err);
      chk("sleep wake", 32'h0, rd[3:2]);
      apb(1'b1, OFS_IRQEN, 32'h1, rd, err);
      apb(1'b1, OFS_SYSCFG, 32'h2, rd, err);
      osc_stop <= 1'b1;
      i = 0;
      while (on_fallback !== 1'b1 && i < 1000) begin
         @(posedge pclk);
         i++;
      end
      if (i == 1000) begin
         n_errors++;
         conclude();
      end
      repeat (2) @(posedge pclk);
      chk("fail irq", 32'h1, irq & on_fallback);
      apb(1'b0, OFS_STATUS, 32'h0, rd, err);
      chk("fail status", 32'h0000_0901, rd);
      measure(1'b1, 2, "fallback presc ticks");
      apb(1'b1, OFS_IRQCLR, 32'h1, rd, err);
      repeat (300) @(posedge pclk);
      chk("irq cleared", 32'h0, irq);
      apb(1'b0, OFS_STATUS, 32'h0, rd, err);
      chk("cleared once", 32'h0000_0900, rd);
      osc_stop <= 1'b0;
      apb(1'b1, OFS_SYSCFG, 32'h0, rd, err);
      repeat (200) @(posedge pclk);
      chk("fallback kept", 32'h1, on_fallback);
      measure(1'b1, 1, "fallback direct ticks");
      apb(1'b1, OFS_CLKMGMT, 32'h0, rd, err);
      apb(1'b1, OFS_SYSCFG, 32'hc, rd, err);
      wake();
      apb(1'b0, OFS_SYSCFG, 32'h0, rd, err);
      chk("power down held", 32'h3, rd[3:2]);
      chk("power down rtc", 32'h0, rtc_run);
      @(posedge pclk);
      presetn <= 1'b0;
      rd_strobe_n <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (3) @(posedge pclk);
      rd_strobe_n <= 1'b1;
      chk("reset leaves fallback", 32'h0, on_fallback);
      chk("idle loop", 32'h0, pll_run);
      apb(1'b0, OFS_SYSCFG, 32'h0, rd, err);
      chk("strap low", 32'h1, rd[SYS_DIS_BIT]);
      apb(1'b1, OFS_IRQEN, 32'h1, rd, err);
      osc_stop <= 1'b1;
      repeat (400) @(posedge pclk);
      chk("no fail irq", 32'h0, {irq, on_fallback});
      apb(1'b0, OFS_STATUS, 32'h0, rd, err);
      chk("no fail status", 32'h0, rd[ST_FAIL_BIT]);
      osc_stop <= 1'b0;
      measure(1'b0, 1, "oscillator path ticks");
      conclude();
   end
endmodule
`default_nettype wire
